// ===== sfb_bank.sv
/*
 special function register bank: decodes the core's direct-address space 0x80-0xff,
 byte and bit access, and exports the register contents the core and peripherals use.
 assumes requests come from core logic on mclk; no synchroniser is needed.
*/
`timescale 1ns/1ps

// Functional notes
// [R1] a read of an unimplemented address returns 0x00 and changes nothing.
// [R2] a write to an unimplemented address leaves all bank state unchanged.
// [R3] registers at addresses with low three bits zero accept single-bit access, others byte only.
// [R4] at reset each register loads its value: mostly zero, port latches all ones, stack seven.
// [R5] at reset serial 0 reload low loads 0xd9 and both reload high bytes load 0x03.
// [R6] the register at 0xbf supplies the high address byte for paged external moves.
// [R7] in the baud rate control register only the top bit is implemented.
// [R8] the register at 0xc8 holds the polarity of external interrupts two and three.
// [R9] the accumulator is the operand holder and also an ordinary readable register.
// [R10] the b register is the second operand and result for multiply and divide, else scratch.
// [R11] the core reaches this space only by direct addressing; indirect goes to ram.
// [R12] pointer select bit zero chooses data pointer 0 when clear and pointer 1 when set.
// [R13] a write takes effect at the edge ending the write, so the next read sees it.
module sfb_bank (
   input wire logic mclk,
   input wire logic reset_n,
   input sfb_pkg::sfb_req_t req,
   input sfb_pkg::sfb_alu_t alu,
   output logic [sfb_pkg::DATA_W-1:0] rdata,
   output logic rbit,
   output logic hit,
   output sfb_pkg::sfb_view_t view
);
   import sfb_pkg::*;

   logic [DATA_W-1:0] regs_r [NUM_REGS];
   logic [DATA_W-1:0] rdata_r;
   logic rbit_r;
   logic [NUM_REGS-1:0] sel;
   logic [DATA_W-1:0] read_mux;
   logic [DATA_W-1:0] bit_mask;

   function automatic logic bit_capable(input logic [ADDR_W-1:0] a);
      return a[2:0] == BIT_ADDR_LOW;
   endfunction : bit_capable

   function automatic logic [DATA_W-1:0] impl_mask(input int idx);
      if (idx == IDX_BAUD) begin
         return BAUD_MSB_MASK; // [R7]
      end else begin
         return ~ZERO_BYTE;
      end
   endfunction : impl_mask

   // address decode; the core addresses this space only directly [R11]
   genvar g;
   generate
      for (g = 0; g < NUM_REGS; g++) begin : g_dec
         assign sel[g] = (req.addr == ADDR_TABLE[g]); // [R1] [R2]
      end
   endgenerate

   assign hit = |sel;
   assign bit_mask = DATA_W'(1) << req.bit_sel;

   always_comb begin
      read_mux = UNMAPPED_READ; // [R1]
      for (int i = 0; i < NUM_REGS; i++) begin
         if (sel[i]) begin
            read_mux = regs_r[i];
         end
      end
   end

   // write path: bit writes only to bit-capable addresses [R3]; alu ports load acc/b
   generate
      for (g = 0; g < NUM_REGS; g++) begin : g_reg
         logic [DATA_W-1:0] nxt;
         logic byte_we;
         logic bit_we;
         assign byte_we = req.wr && !req.bit_op && sel[g];
         assign bit_we = req.wr && req.bit_op && sel[g] && bit_capable(req.addr); // [R3]
         always_comb begin
            nxt = regs_r[g];
            if (byte_we) begin
               nxt = req.wdata; // [R13]
            end else if (bit_we) begin
               nxt = req.wdata[0] ? (regs_r[g] | bit_mask) : (regs_r[g] & ~bit_mask);
            end
            if (g == IDX_ACCUM && alu.acc_we) begin
               nxt = alu.acc_wdata; // [R9]
            end else if (g == IDX_B && alu.b_we) begin
               nxt = alu.b_wdata; // [R10]
            end
         end
         always_ff @(posedge mclk or negedge reset_n) begin
            if (!reset_n) begin
               regs_r[g] <= RESET_TABLE[g]; // [R4] [R5]
            end else begin
               regs_r[g] <= nxt & impl_mask(g);
            end
         end
      end
   endgenerate

   // read data registered; reads have no side effects [R1]
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         rdata_r <= ZERO_BYTE;
         rbit_r <= 1'b0;
      end else if (req.rd) begin
         rdata_r <= read_mux;
         rbit_r <= bit_capable(req.addr) ? read_mux[req.bit_sel] : 1'b0; // [R3]
      end
   end

   assign rdata = rdata_r;
   assign rbit = rbit_r;

   // exported views
   assign view.data_pointer = regs_r[IDX_POINTER_SELECT][POINTER_SEL_BIT] ?
      {regs_r[IDX_DP1_HIGH], regs_r[IDX_DP1_LOW]} :
      {regs_r[IDX_DP0_HIGH], regs_r[IDX_DP0_LOW]}; // [R12]
   assign view.movx_page_high = regs_r[IDX_MOVX_PAGE]; // [R6]
   assign view.accumulator = regs_r[IDX_ACCUM]; // [R9]
   assign view.multiply_operand = regs_r[IDX_B]; // [R10]
   assign view.program_status_word = regs_r[IDX_STATUS_WORD];
   assign view.ext_external_interrupt_two_polarity = regs_r[IDX_EXT_IRQ_POL][POL_EXTERNAL_INTERRUPT_TWO_BIT]; // [R8]
   assign view.ext_external_interrupt_three_polarity = regs_r[IDX_EXT_IRQ_POL][POL_EXTERNAL_INTERRUPT_THREE_BIT]; // [R8]
   assign view.baud_rate_control_msb = regs_r[IDX_BAUD][BAUD_MSB_BIT]; // [R7]
endmodule : sfb_bank

// ===== sfb_pkg.sv
/*
 special function register bank package: addresses, reset values, bus carriers.
 assumes a single core clock domain; no other package is needed.
*/
package sfb_pkg;
   localparam int ADDR_W = 8;
   localparam int DATA_W = 8;
   localparam int NUM_REGS = 38;
   localparam logic [2:0] BIT_ADDR_LOW = 3'h0;
   localparam logic [7:0] BAUD_MSB_MASK = 8'h80;
   localparam int BAUD_MSB_BIT = 7;
   localparam int POINTER_SEL_BIT = 0;
   localparam logic [7:0] ZERO_BYTE = 8'h00;
   localparam logic [7:0] UNMAPPED_READ = 8'h00;

   localparam logic [7:0] ADDR_TABLE [NUM_REGS] = '{
      8'h80, 8'h81, 8'h82, 8'h83, 8'h84, 8'h85, 8'h86, 8'h87,
      8'h88, 8'h89, 8'h8a, 8'h8b, 8'h8c, 8'h8d, 8'h8e, 8'h90,
      8'h92, 8'h98, 8'h99, 8'h9a, 8'h9b, 8'h9c, 8'h9d, 8'ha0,
      8'ha8, 8'ha9, 8'haa, 8'hb8, 8'hb9, 8'hba, 8'hbb, 8'hbf,
      8'hc0, 8'hc8, 8'hd0, 8'hd8, 8'he0, 8'hf0};

   localparam logic [7:0] RESET_TABLE [NUM_REGS] = '{
      8'hff, 8'h07, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
      8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h01, 8'hff,
      8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
      8'h00, 8'h00, 8'hd9, 8'h00, 8'h00, 8'h03, 8'h03, 8'h00,
      8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};

   // indices into the tables
   localparam int IDX_DP0_LOW = 2;
   localparam int IDX_DP0_HIGH = 3;
   localparam int IDX_DP1_LOW = 4;
   localparam int IDX_DP1_HIGH = 5;
   localparam int IDX_POINTER_SELECT = 16;
   localparam int IDX_MOVX_PAGE = 31;
   localparam int IDX_EXT_IRQ_POL = 33;
   localparam int IDX_STATUS_WORD = 34;
   localparam int IDX_BAUD = 35;
   localparam int IDX_ACCUM = 36;
   localparam int IDX_B = 37;
   localparam int POL_EXTERNAL_INTERRUPT_TWO_BIT = 0;
   localparam int POL_EXTERNAL_INTERRUPT_THREE_BIT = 1;

   typedef struct packed {
      logic rd;
      logic wr;
      logic bit_op;
      logic [ADDR_W-1:0] addr;
      logic [2:0] bit_sel;
      logic [DATA_W-1:0] wdata;
   } sfb_req_t;

   typedef struct packed {
      logic acc_we;
      logic [DATA_W-1:0] acc_wdata;
      logic b_we;
      logic [DATA_W-1:0] b_wdata;
   } sfb_alu_t;

   typedef struct packed {
      logic [15:0] data_pointer;
      logic [7:0] movx_page_high;
      logic [7:0] accumulator;
      logic [7:0] multiply_operand;
      logic [7:0] program_status_word;
      logic ext_external_interrupt_two_polarity;
      logic ext_external_interrupt_three_polarity;
      logic baud_rate_control_msb;
   } sfb_view_t;
endpackage : sfb_pkg

// ===== sfb_bank_properties.sv
/* checker on sfb_bank ports; bound below to every sfb_bank */
`timescale 1ns/1ps
module sfb_bank_properties (
   input wire logic mclk,
   input wire logic reset_n,
   input sfb_pkg::sfb_req_t req,
   input sfb_pkg::sfb_alu_t alu,
   input wire logic [7:0] rdata,
   input wire logic rbit,
   input wire logic hit,
   input sfb_pkg::sfb_view_t view
);
   import sfb_pkg::*;
   default clocking @(posedge mclk); endclocking
   default disable iff (!reset_n);
   sequence s_wr_rd;
      req.wr && !req.bit_op && hit && req.addr < 8'hd0 ##1
      req.rd && !req.bit_op && req.addr == $past(req.addr);
   endsequence
   a_unmapped_read: assert property (req.rd && !req.bit_op && !hit |=> !rdata)
      else $error("unmapped read");
   a_unmapped_write: assert property (req.wr && !hit && !alu.acc_we && !alu.b_we
      |=> $stable(view)) else $error("unmapped write");
   a_bit_aligned: assert property (req.rd && req.bit_op && req.addr[2:0] |=> !rbit)
      else $error("bit read");
   a_page_write: assert property (req.wr && !req.bit_op && req.addr == 8'hbf
      |=> view.movx_page_high == $past(req.wdata)) else $error("page");
   a_baud_low: assert property (req.rd && !req.bit_op && req.addr == 8'hd8
      |=> rdata[6:0] == 7'h00) else $error("baud");
   a_acc_load: assert property (alu.acc_we |=> view.accumulator == $past(alu.acc_wdata))
      else $error("acc");
   a_b_load: assert property (alu.b_we |=> view.multiply_operand == $past(alu.b_wdata))
      else $error("b");
   a_write_read: assert property (s_wr_rd |=> rdata == $past(req.wdata, 2))
      else $error("readback");
endmodule : sfb_bank_properties
bind sfb_bank sfb_bank_properties i_props (.mclk(mclk), .reset_n(reset_n), .req(req),
   .alu(alu), .rdata(rdata), .rbit(rbit), .hit(hit), .view(view));

// ===== sfb_core_model.sv
/* core requester for sfb_bank; outputs move 1 ns after mclk rises */
`timescale 1ns/1ps
module sfb_core_model (
   input wire logic mclk,
   output sfb_pkg::sfb_req_t req,
   output sfb_pkg::sfb_alu_t alu
);
   import sfb_pkg::*;
   // rw 1 reads, 2 writes, 0 idles
   task bus(input int rw, input logic [7:0] ad, dv = 8'h5a, input logic b = 1'b0,
      input logic [2:0] s = 3'h0, input sfb_alu_t al = '0);
      req = '{rw[0], rw[1], b, ad | 8'h80, s, dv};
      alu = al;
      @(posedge mclk);
      #1;
   endtask : bus
endmodule : sfb_core_model

// ===== sfb_bank_tb_top.sv
/* bench for sfb_bank: reset values, random traffic, bit access, loads */
`timescale 1ns/1ps
module sfb_bank_tb_top;
   import sfb_pkg::*;
   logic mclk = 1'b0, reset_n = 1'b0, rbit, hit;
   logic [7:0] rdata, a, d, sh [256];
   sfb_req_t req;
   sfb_alu_t alu;
   sfb_view_t view;
   int err_count = 0, n_compared = 0;
   sfb_bank i_sfb_bank (.mclk(mclk), .reset_n(reset_n), .req(req), .alu(alu),
      .rdata(rdata), .rbit(rbit), .hit(hit), .view(view));
   sfb_core_model i_core (.mclk(mclk), .req(req), .alu(alu));
   function automatic logic [7:0] expect_of(input logic [7:0] ad, dv);
      expect_of = 8'h00;
      for (int i = 0; i < NUM_REGS; i++)
         if (ADDR_TABLE[i] == ad) expect_of = ad == 8'hd8 ? dv & 8'h80 : dv;
   endfunction : expect_of
   task chk(input string n, input logic [7:0] e, g);
      n_compared++;
      if (g !== e) begin
         err_count++;
         $display("CHECK FAILED %s expected %h seen %h", n, e, g);
      end
   endtask : chk
   task tally_and_finish();
      $display("compared %0d mismatches %0d", n_compared, err_count);
      if (err_count == 0 && n_compared > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask : tally_and_finish
   initial forever #5 mclk = ~mclk;
   initial begin
      #200us;
      err_count++;
      tally_and_finish();
   end
   initial begin
      d = 8'($urandom(32'h335f));
      repeat (20) i_core.bus(0, d);
      reset_n = 1'b1;
      for (int i = 0; i < NUM_REGS; i++) begin
         a = ADDR_TABLE[i];
         sh[a] = RESET_TABLE[i];
         i_core.bus(1, a);
         chk("reset", sh[a], rdata);
      end
      $display("reset done");
      for (int i = 0; i < 400; i++) begin
         a = i % 2 ? ADDR_TABLE[$urandom % NUM_REGS] : {1'b1, 7'($urandom)};
         a = a == 8'hd0 ? 8'hd1 : a;
         d = 8'($urandom);
         i_core.bus(2, a, d);
         i_core.bus(1, a, ~d);
         sh[a] = expect_of(a, d);
         chk("byte", sh[a], rdata);
      end
      i_core.bus(2, 8'h92, 8'h01);
      chk("pointer", sh[8'h85], view.data_pointer[15:8]);
      $display("byte done");
      for (int i = 0; i < NUM_REGS; i++) begin
         a = ADDR_TABLE[i];
         d = 8'($urandom % 8);
         if (a == 8'hd0 || a == 8'hd8) continue;
         i_core.bus(2, a, ~sh[a] >> d, 1'b1, d[2:0]);
         i_core.bus(1, a, d, 1'b1, d[2:0]);
         chk("bit", {7'h0, ~sh[a][d] & (a[2:0] == 3'h0)}, {7'h0, rbit});
      end
      $display("bit done");
      i_core.bus(0, ~a, d, 1'b0, 3'h0, '{1'b1, d, 1'b1, ~d});
      chk("b", ~d, view.multiply_operand);
      chk("acc", d, view.accumulator);
      i_core.bus(2, 8'hc8, 8'h02);
      chk("external_interrupt_two pol", 8'h00, {7'h0, view.ext_external_interrupt_two_polarity});
      chk("external_interrupt_three pol", 8'h01, {7'h0, view.ext_external_interrupt_three_polarity});
      i_core.bus(2, 8'hd8, 8'hff);
      chk("baud msb", 8'h01, {7'h0, view.baud_rate_control_msb});
      i_core.bus(2, 8'hd0, d);
      chk("status", d, view.program_status_word);
      i_core.bus(0, a);
      $display("load done");
      tally_and_finish();
   end
endmodule : sfb_bank_tb_top
